// ==== b4dsp_ctrl.sv ====
// Controller end: command FIFO and burst sequencer driving the port
`include "b4dsp_defs.svh"
module b4dsp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = `B4_FIFO_DEPTH
)(
  input  wire logic         i_sys_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_ce,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] buf_q [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0]   cnt_q;
  logic [PW:0]   cnt_d;
  logic          push;
  logic          pop;

  assign o_valid = (cnt_q != '0);
  assign o_data  = buf_q[rp_q];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;
  assign cnt_d   = cnt_q + (PW+1)'(push) - (PW+1)'(pop);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_ce && push)
      buf_q[wp_q] <= i_data;
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wp_q    <= '0;
      rp_q    <= '0;
      cnt_q   <= '0;
      o_ready <= 1'b0;
    end
    else if (i_ce)
    begin
      if (push)
        wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      if (pop)
        rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      cnt_q   <= cnt_d;
      o_ready <= (cnt_d != (PW+1)'(DEPTH));
    end
  end
endmodule : b4dsp_fifo

module b4dsp_ctrl
  import b4dsp_pkg::*;
#(
  parameter int ADDR_W = `B4_ADDR_W,
  parameter int DEPTH  = `B4_FIFO_DEPTH
)(
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_ce,
  input  wire logic                      i_clk_run,
  input  wire logic                      i_cmd_valid,
  output logic                           o_cmd_ready,
  input  wire logic                      i_cmd_write,
  input  wire logic [ADDR_W-1:0]         i_cmd_addr,
  input  wire logic [`B4_BURST_BITS-1:0] i_cmd_data,
  input  wire logic [`B4_MASK_BITS-1:0]  i_cmd_mask_n,
  output b4dsp_word_t                    o_rd_data,
  output logic                           o_rd_valid,
  b4dsp_if.ctl                           port
);
  localparam int CW = 1 + ADDR_W + `B4_BURST_BITS + `B4_MASK_BITS;
  // ---------------------------------------------------------------
  // Command buffer
  // ---------------------------------------------------------------
  logic          f_valid;
  logic          f_pop;
  logic [CW-1:0] f_data;
  logic          h_write;
  logic [ADDR_W-1:0] h_addr;
  logic [`B4_BURST_BITS-1:0] h_wdata;
  logic [`B4_MASK_BITS-1:0]  h_mask;
  assign {h_write, h_addr, h_wdata, h_mask} = f_data;

  b4dsp_fifo #(.W(CW), .DEPTH(DEPTH)) u_b4dsp_fifo (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .i_valid   (i_cmd_valid),
    .o_ready   (o_cmd_ready),
    .i_data    ({i_cmd_write, i_cmd_addr, i_cmd_data, i_cmd_mask_n}),
    .o_valid   (f_valid),
    .i_ready   (f_pop),
    .o_data    (f_data)
  );

  // ---------------------------------------------------------------
  // Input clock pair generation
  // ---------------------------------------------------------------
  b4dsp_kphase_e kph_q;
  b4dsp_kphase_e kph_d;
  logic          k_d;
  logic          kb_d;
  logic          k_q;
  logic          kb_q;
  logic          edge_now;
  logic          krise_now;

  always_comb
  begin
    case (kph_q)
      KS_KRISE:  kph_d = i_clk_run ? KS_KBRISE : KS_PARK;
      KS_KBRISE: kph_d = i_clk_run ? KS_KRISE : KS_PARK;
      default:   kph_d = i_clk_run ? KS_KBRISE : KS_PARK;
    endcase
  end
  assign k_d       = (kph_d != KS_KBRISE);
  assign kb_d      = (kph_d != KS_KRISE);
  assign krise_now = k_d & ~k_q;
  assign edge_now  = krise_now | (kb_d & ~kb_q);

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      kph_q <= KS_PARK;
      k_q   <= 1'b1;
      kb_q  <= 1'b1;
    end
    else if (i_ce)
    begin
      kph_q <= kph_d;
      k_q   <= k_d;
      kb_q  <= kb_d;
    end
  end

  // ---------------------------------------------------------------
  // Operation issue at each K rise
  // ---------------------------------------------------------------
  logic issue_rd;
  logic issue_wr;
  logic last_rd_q;
  logic last_wr_q;
  logic rps_n_q;
  logic wps_n_q;
  logic [ADDR_W-1:0] addr_q;
  assign issue_rd = krise_now & f_valid & ~h_write & ~last_rd_q;
  assign issue_wr = krise_now & f_valid & h_write & ~last_wr_q;
  assign f_pop    = i_ce & (issue_rd | issue_wr);

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      last_rd_q <= 1'b0;
      last_wr_q <= 1'b0;
      rps_n_q   <= 1'b1;
      wps_n_q   <= 1'b1;
      addr_q    <= '0;
    end
    else if (i_ce && krise_now)
    begin
      last_rd_q <= issue_rd;
      last_wr_q <= issue_wr;
      rps_n_q   <= ~issue_rd;
      wps_n_q   <= ~issue_wr;
      if (issue_rd || issue_wr)
        addr_q <= h_addr;
    end
  end

  // ---------------------------------------------------------------
  // Write data beats, two rises after the address
  // ---------------------------------------------------------------
  logic                      pend_v_q;
  logic                      pend_age_q;
  logic [`B4_BURST_BITS-1:0] pend_d_q;
  logic [`B4_MASK_BITS-1:0]  pend_m_q;
  logic [`B4_BURST_BITS-1:0] sh_d_q;
  logic [`B4_MASK_BITS-1:0]  sh_m_q;
  b4dsp_beat_t               sh_cnt_q;
  b4dsp_word_t               d_q;
  logic [1:0]                lane_q;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pend_v_q   <= 1'b0;
      pend_age_q <= 1'b0;
      pend_d_q   <= '0;
      pend_m_q   <= '1;
      sh_d_q     <= '0;
      sh_m_q     <= '1;
      sh_cnt_q   <= `B4_BEAT_ZERO;
      d_q        <= '0;
      lane_q     <= 2'h3;
    end
    else if (i_ce && edge_now)
    begin
      if (issue_wr)
      begin
        pend_v_q   <= 1'b1;
        pend_age_q <= 1'b0;
        pend_d_q   <= h_wdata;
        pend_m_q   <= h_mask;
      end
      else if (pend_v_q && !pend_age_q)
        pend_age_q <= 1'b1;
      else if (pend_v_q)
        pend_v_q <= 1'b0;
      if (pend_v_q && pend_age_q && !issue_wr)
      begin
        d_q      <= pend_d_q[`B4_WORD_W-1:0];
        lane_q   <= pend_m_q[`B4_LANE_W-1:0];
        sh_d_q   <= pend_d_q >> `B4_WORD_W;
        sh_m_q   <= pend_m_q >> `B4_LANE_W;
        sh_cnt_q <= `B4_LAST_BEAT;
      end
      else if (sh_cnt_q != `B4_BEAT_ZERO)
      begin
        d_q      <= sh_d_q[`B4_WORD_W-1:0];
        lane_q   <= sh_m_q[`B4_LANE_W-1:0];
        sh_d_q   <= sh_d_q >> `B4_WORD_W;
        sh_m_q   <= sh_m_q >> `B4_LANE_W;
        sh_cnt_q <= sh_cnt_q - `B4_BEAT_ONE;
      end
      else
        lane_q <= 2'h3;
    end
  end

  // ---------------------------------------------------------------
  // Read data return
  // ---------------------------------------------------------------
  logic [`B4_RET_DLY-1:0] cap_q;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cap_q      <= '0;
      o_rd_data  <= '0;
      o_rd_valid <= 1'b0;
    end
    else if (i_ce)
    begin
      cap_q      <= {cap_q[`B4_RET_DLY-2:0], edge_now};
      o_rd_valid <= cap_q[`B4_RET_DLY-1] & port.q_oe;
      if (cap_q[`B4_RET_DLY-1] && port.q_oe)
        o_rd_data <= port.q;
    end
  end

  assign port.k                        = k_q;
  assign port.kb                       = kb_q;
  assign port.addr                     = addr_q;
  assign port.read_port_select_n       = rps_n_q;
  assign port.write_port_select_n      = wps_n_q;
  assign port.d                        = d_q;
  assign port.low_lane_write_select_n  = lane_q[0];
  assign port.high_lane_write_select_n = lane_q[1];
endmodule : b4dsp_ctrl

// ==== b4dsp_defs.svh ====
// Constants shared by both ends of the burst-of-four port
`ifndef B4DSP_DEFS_SVH
`define B4DSP_DEFS_SVH
`define B4_ADDR_W      20
`define B4_WORD_W      18
`define B4_LO_MSB      8
`define B4_HI_LSB      9
`define B4_HI_MSB      17
`define B4_BURST_BITS  72
`define B4_MASK_BITS   8
`define B4_LANE_W      2
`define B4_LAST_BEAT   2'h3
`define B4_BEAT_ZERO   2'h0
`define B4_BEAT_ONE    2'h1
`define B4_RD_LAUNCH   5
`define B4_WR_CAPTURE  2
`define B4_RET_DLY     3
`define B4_FIFO_DEPTH  8
`define B4_BURST_LEN   4
`endif

// ==== b4dsp_device.sv ====
// Memory end: burst-of-four double-data-rate port with its array
// How it works
// - write address at K rise, data two edges later
// - read data starts at K# rise of t+2
// - read starts on low read select only
// - burst goes to base, base+1, +2, +3
// - after reset outputs undriven until a read
// - write words captured on both clock rises
// - read words launched on both clock rises
// - back-to-back same-kind starts are dropped
// - select used last cycle is ignored now
// - stopped clocks hold all pins as before
// - both lane selects low write all bits
// - low lane only writes bits 8 to 0
// - high lane only writes bits 17 to 9
// - both lane selects high write nothing
// - lane selects sampled with every word
// - write starts on low write select
// - both selects from idle: read first, alternate
// - read after write returns fresh data
`include "b4dsp_defs.svh"
module b4dsp_device
  import b4dsp_pkg::*;
#(
  parameter int ADDR_W = `B4_ADDR_W
)(
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  input  wire logic i_ce,
  b4dsp_if.dev      port
);
  // ---------------------------------------------------------------
  // Input sampling and edge detection
  // ---------------------------------------------------------------
  logic              k_s_q;
  logic              kb_s_q;
  logic              k_p_q;
  logic              kb_p_q;
  logic [ADDR_W-1:0] addr_s_q;
  logic              rps_s_q;
  logic              wps_s_q;
  b4dsp_word_t       d_s_q;
  logic [1:0]        lane_s_q;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      k_s_q    <= 1'b1;
      kb_s_q   <= 1'b1;
      k_p_q    <= 1'b1;
      kb_p_q   <= 1'b1;
      addr_s_q <= '0;
      rps_s_q  <= 1'b1;
      wps_s_q  <= 1'b1;
      d_s_q    <= '0;
      lane_s_q <= 2'h3;
    end
    else if (i_ce)
    begin
      k_s_q    <= port.k;
      kb_s_q   <= port.kb;
      k_p_q    <= k_s_q;
      kb_p_q   <= kb_s_q;
      addr_s_q <= port.addr;
      rps_s_q  <= port.read_port_select_n;
      wps_s_q  <= port.write_port_select_n;
      d_s_q    <= port.d;
      lane_s_q <= {port.high_lane_write_select_n, port.low_lane_write_select_n};
    end
  end

  logic k_edge;
  logic kb_edge;
  logic any_edge;
  assign k_edge   = k_s_q & ~k_p_q;
  assign kb_edge  = kb_s_q & ~kb_p_q;
  assign any_edge = (k_edge | kb_edge) & i_ce;

  // ---------------------------------------------------------------
  // Start decode and arbitration
  // ---------------------------------------------------------------
  logic rd_last_q;
  logic wr_last_q;
  logic rd_go;
  logic wr_go;
  assign rd_go = k_edge & ~rps_s_q & ~rd_last_q;
  assign wr_go = k_edge & ~wps_s_q & ~wr_last_q & ~rd_go;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rd_last_q <= 1'b0;
      wr_last_q <= 1'b0;
    end
    else if (i_ce && k_edge)
    begin
      rd_last_q <= rd_go;
      wr_last_q <= wr_go;
    end
  end

  // ---------------------------------------------------------------
  // Latency pipes, one stage per clock rise
  // ---------------------------------------------------------------
  logic              rd_pv_q [`B4_RD_LAUNCH];
  logic [ADDR_W-1:0] rd_pa_q [`B4_RD_LAUNCH];
  logic              wr_pv_q [`B4_WR_CAPTURE];
  logic [ADDR_W-1:0] wr_pa_q [`B4_WR_CAPTURE];

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      for (int i = 0; i < `B4_RD_LAUNCH; i++)
      begin
        rd_pv_q[i] <= 1'b0;
        rd_pa_q[i] <= '0;
      end
      for (int i = 0; i < `B4_WR_CAPTURE; i++)
      begin
        wr_pv_q[i] <= 1'b0;
        wr_pa_q[i] <= '0;
      end
    end
    else if (any_edge)
    begin
      rd_pv_q[0] <= rd_go;
      rd_pa_q[0] <= addr_s_q;
      wr_pv_q[0] <= wr_go;
      wr_pa_q[0] <= addr_s_q;
      for (int i = 1; i < `B4_RD_LAUNCH; i++)
      begin
        rd_pv_q[i] <= rd_pv_q[i-1];
        rd_pa_q[i] <= rd_pa_q[i-1];
      end
      for (int i = 1; i < `B4_WR_CAPTURE; i++)
      begin
        wr_pv_q[i] <= wr_pv_q[i-1];
        wr_pa_q[i] <= wr_pa_q[i-1];
      end
    end
  end

  // ---------------------------------------------------------------
  // Burst beat tracking
  // ---------------------------------------------------------------
  logic              wr_act_q;
  b4dsp_beat_t       wr_beat_q;
  logic [ADDR_W-1:0] wr_base_q;
  logic              rd_act_q;
  b4dsp_beat_t       rd_beat_q;
  b4dsp_word_t       rd_buf_q [`B4_BURST_LEN];
  logic              wr_new;
  logic              rd_new;
  logic              wr_en;
  logic              rd_en;
  logic [ADDR_W-1:0] wr_idx;
  b4dsp_beat_t       rd_sel;

  assign wr_new = wr_pv_q[`B4_WR_CAPTURE-1];
  assign rd_new = rd_pv_q[`B4_RD_LAUNCH-1];
  assign wr_en  = any_edge & (wr_new | wr_act_q);
  assign rd_en  = any_edge & (rd_new | rd_act_q);
  assign wr_idx = wr_new ? wr_pa_q[`B4_WR_CAPTURE-1]
                         : wr_base_q + ADDR_W'(wr_beat_q);
  assign rd_sel = rd_new ? `B4_BEAT_ZERO : rd_beat_q;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_act_q  <= 1'b0;
      wr_beat_q <= `B4_BEAT_ZERO;
      wr_base_q <= '0;
    end
    else if (any_edge)
    begin
      if (wr_new)
      begin
        wr_base_q <= wr_pa_q[`B4_WR_CAPTURE-1];
        wr_beat_q <= `B4_BEAT_ONE;
        wr_act_q  <= 1'b1;
      end
      else if (wr_act_q)
      begin
        wr_beat_q <= wr_beat_q + `B4_BEAT_ONE;
        wr_act_q  <= (wr_beat_q != `B4_LAST_BEAT);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rd_act_q  <= 1'b0;
      rd_beat_q <= `B4_BEAT_ZERO;
    end
    else if (any_edge)
    begin
      if (rd_new)
      begin
        rd_beat_q <= `B4_BEAT_ONE;
        rd_act_q  <= 1'b1;
      end
      else if (rd_act_q)
      begin
        rd_beat_q <= rd_beat_q + `B4_BEAT_ONE;
        rd_act_q  <= (rd_beat_q != `B4_LAST_BEAT);
      end
    end
  end

  // ---------------------------------------------------------------
  // Array with per-lane write masking
  // ---------------------------------------------------------------
  b4dsp_word_t mem_q [2**ADDR_W];

  always_ff @(posedge i_sys_clk)
  begin
    if (wr_en)
    begin
      if (!lane_s_q[0])
        mem_q[wr_idx][`B4_LO_MSB:0] <= d_s_q[`B4_LO_MSB:0];
      if (!lane_s_q[1])
        mem_q[wr_idx][`B4_HI_MSB:`B4_HI_LSB] <= d_s_q[`B4_HI_MSB:`B4_HI_LSB];
    end
  end

  // Whole burst fetched one rise before launch, so a later write cannot leak in
  always_ff @(posedge i_sys_clk)
  begin
    if (any_edge && rd_pv_q[`B4_RD_LAUNCH-2])
    begin
      for (int i = 0; i < `B4_BURST_LEN; i++)
        rd_buf_q[i] <= mem_q[rd_pa_q[`B4_RD_LAUNCH-2] + ADDR_W'(i)];
    end
  end

  // ---------------------------------------------------------------
  // Read output register
  // ---------------------------------------------------------------
  b4dsp_word_t q_q;
  logic        q_oe_q;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      q_q    <= '0;
      q_oe_q <= 1'b0;
    end
    else if (rd_en)
    begin
      q_q    <= rd_buf_q[rd_sel];
      q_oe_q <= 1'b1;
    end
    else if (any_edge)
      q_oe_q <= 1'b0;
  end

  assign port.q    = q_q;
  assign port.q_oe = q_oe_q;
endmodule : b4dsp_device

// ==== b4dsp_if.sv ====
// Pin bundle between controller and memory port
interface b4dsp_if #(parameter int ADDR_W = 20);
  logic              k;
  logic              kb;
  logic [ADDR_W-1:0] addr;
  logic              read_port_select_n;
  logic              write_port_select_n;
  logic [17:0]       d;
  logic              low_lane_write_select_n;
  logic              high_lane_write_select_n;
  logic [17:0]       q;
  logic              q_oe;

  modport dev (
    input  k, kb, addr, read_port_select_n, write_port_select_n, d,
    input  low_lane_write_select_n, high_lane_write_select_n,
    output q, q_oe
  );
  modport ctl (
    output k, kb, addr, read_port_select_n, write_port_select_n, d,
    output low_lane_write_select_n, high_lane_write_select_n,
    input  q, q_oe
  );
endinterface : b4dsp_if

// ==== b4dsp_pkg.sv ====
// Types shared by both ends of the burst-of-four port
package b4dsp_pkg;
  typedef enum logic [1:0] {
    KS_PARK   = 2'h0,
    KS_KRISE  = 2'h1,
    KS_KBRISE = 2'h3
  } b4dsp_kphase_e;
  typedef logic [17:0] b4dsp_word_t;
  typedef logic [1:0]  b4dsp_beat_t;
endpackage : b4dsp_pkg

// ==== b4dsp_props.sv ====
// Pin-level checks between controller and memory port
module b4dsp_props #(
  parameter int ADDR_W = 20
)(
  input wire logic              i_sys_clk,
  input wire logic              i_reset_n,
  input wire logic              k,
  input wire logic              kb,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              read_port_select_n,
  input wire logic              write_port_select_n,
  input wire logic [17:0]       d,
  input wire logic              low_lane_write_select_n,
  input wire logic              high_lane_write_select_n,
  input wire logic [17:0]       q,
  input wire logic              q_oe
);
  logic       k_prev_q;
  logic       seen_rd_q;
  logic [7:0] run_q;
  logic       rd_pin;
  logic       wr_pin;
  logic       lane_on;

  // ----------------------------------------
  // Rise detection and burst length
  // ----------------------------------------
  assign rd_pin  = k & ~k_prev_q & ~read_port_select_n;
  assign wr_pin  = k & ~k_prev_q & ~write_port_select_n;
  assign lane_on = ~low_lane_write_select_n | ~high_lane_write_select_n;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      k_prev_q  <= 1'h1;
      seen_rd_q <= 1'h0;
      run_q     <= 8'h00;
    end
    else
    begin
      k_prev_q  <= k;
      seen_rd_q <= seen_rd_q | rd_pin;
      // Top bit dropped so long runs never wrap to zero
      run_q     <= q_oe ? {1'b0, run_q[6:0]} + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_rd_start;
    rd_pin;
  endsequence
  sequence s_burst;
    q_oe [*4];
  endsequence
  sequence s_parked;
    (k && kb) [*3];
  endsequence

  a_read_latency: assert property (s_rd_start |-> ##7 s_burst)
    else $error("read burst late or short");
  a_burst_words: assert property ($fell(q_oe) |-> run_q[1:0] == 2'h0 && run_q != 8'h00)
    else $error("read burst not four words");
  a_idle_tristate: assert property (!seen_rd_q |-> !q_oe)
    else $error("output driven before any read");
  a_park_hold: assert property (s_parked |-> $stable(q) && $stable(q_oe)
    && $stable(addr) && $stable(d))
    else $error("pins moved with clocks stopped");
  a_clock_alternate: assert property ((k ^ kb) && $past(k ^ kb) |-> k != $past(k))
    else $error("clock pair not alternating");
  a_addr_at_rise: assert property ($changed(addr) |-> k && !k_prev_q)
    else $error("address moved off a K rise");
  a_lane_in_slot: assert property (lane_on |-> $past(wr_pin, 2) || $past(wr_pin, 3)
    || $past(wr_pin, 4) || $past(wr_pin, 5))
    else $error("lane select outside data slot");
  a_no_b2b_reads: assert property (s_rd_start |=> !rd_pin ##1 !rd_pin)
    else $error("reads on consecutive K rises");
  a_no_b2b_writes: assert property (wr_pin |=> !wr_pin [*2])
    else $error("writes on consecutive K rises");
endmodule : b4dsp_props

// ==== burst4_ddr_sram_port_bench.sv ====
// Bench joining controller and memory port, plus a rule-breaking driver
`include "b4dsp_defs.svh"
module burst4_ddr_sram_port_bench
  import b4dsp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AW = 6;
  logic          i_sys_clk;
  logic          i_reset_n;
  logic          clk_run;
  logic          cmd_valid;
  logic          cmd_write;
  logic [AW-1:0] cmd_addr;
  logic [71:0]   cmd_data;
  logic [7:0]    cmd_mask_n;
  logic          cmd_ready;
  logic          rd_valid;
  logic          ok;
  logic [AW-1:0] a;
  logic [31:0]   seed;
  b4dsp_word_t   rd_data;
  b4dsp_word_t   mem [64];
  b4dsp_word_t   exp_q [$];
  b4dsp_word_t   exp2_q [$];
  b4dsp_word_t   fw [8];
  int            n_errors;
  int            n_tests;
  int            acc;

  b4dsp_if #(.ADDR_W(AW)) port_if ();
  b4dsp_if #(.ADDR_W(AW)) flt_if ();

  b4dsp_ctrl #(.ADDR_W(AW)) u_b4dsp_ctrl (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_ce(1'h1), .i_clk_run(clk_run), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
    .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr), .i_cmd_data(cmd_data),
    .i_cmd_mask_n(cmd_mask_n), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .port(port_if.ctl));
  b4dsp_device #(.ADDR_W(AW)) u_b4dsp_device (.i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n), .i_ce(1'h1), .port(port_if.dev));
  b4dsp_device #(.ADDR_W(AW)) u_b4dsp_device_flt (.i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n), .i_ce(1'h1), .port(flt_if.dev));
  b4dsp_props #(.ADDR_W(AW)) u_b4dsp_props (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .k(port_if.k), .kb(port_if.kb), .addr(port_if.addr),
    .read_port_select_n(port_if.read_port_select_n),
    .write_port_select_n(port_if.write_port_select_n), .d(port_if.d),
    .low_lane_write_select_n(port_if.low_lane_write_select_n),
    .high_lane_write_select_n(port_if.high_lane_write_select_n),
    .q(port_if.q), .q_oe(port_if.q_oe));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // Push one command; the model is updated in command order
  task automatic push(input logic wr, input logic [AW-1:0] ba, input logic [71:0] dat,
                      input logic [7:0] mk, input int lim, output logic tk);
    int            n;
    logic [AW-1:0] ai;
    @(posedge i_sys_clk);
    cmd_valid  <= 1'h1;
    cmd_write  <= wr;
    cmd_addr   <= ba;
    cmd_data   <= dat;
    cmd_mask_n <= mk;
    n = 0;
    do
    begin
      @(negedge i_sys_clk);
      n++;
    end while (cmd_ready !== 1'h1 && n < lim);
    tk = (cmd_ready === 1'h1);
    @(posedge i_sys_clk);
    cmd_valid <= 1'h0;
    if (lim > 100)
      check("cmd_taken", 32'(tk), 32'h1);
    for (int i = 0; i < 4 && tk; i++)
    begin
      ai = ba + AW'(i);
      if (!wr)
        exp_q.push_back(mem[ai]);
      if (wr && !mk[2*i])
        mem[ai][8:0] = dat[18*i +: 9];
      if (wr && !mk[2*i+1])
        mem[ai][17:9] = dat[18*i+9 +: 9];
    end
  endtask : push

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() + exp2_q.size() != 0 && n < 4000)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    repeat (12) @(posedge i_sys_clk);
    check("pending", 32'(exp_q.size() + exp2_q.size()), 32'h0);
  endtask : drain

  // One cycle of pins on the rule-breaking link
  task automatic st(input logic kk, input logic r, input logic w, input logic [AW-1:0] ad,
                    input b4dsp_word_t dd, input logic [1:0] ln);
    @(posedge i_sys_clk);
    flt_if.k                        <= kk;
    flt_if.kb                       <= ~kk;
    flt_if.read_port_select_n       <= r;
    flt_if.write_port_select_n      <= w;
    flt_if.addr                     <= ad;
    flt_if.d                        <= dd;
    flt_if.low_lane_write_select_n  <= ln[0];
    flt_if.high_lane_write_select_n <= ln[1];
  endtask : st

  // ----------------------------------------
  // Clock, result monitor, watchdog, sequence
  // ----------------------------------------
  initial
  begin
    i_sys_clk = 1'h0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  always @(negedge i_sys_clk)
  begin
    if (rd_valid === 1'h1)
      check("rd_word", 32'(rd_data), exp_q.size() ? 32'(exp_q.pop_front()) : '1);
    if (flt_if.q_oe === 1'h1)
      check("flt_word", 32'(flt_if.q), exp2_q.size() ? 32'(exp2_q.pop_front()) : '1);
  end

  initial
  begin
    #(50 * 40000);
    n_errors++;
    $display("Watchdog expired");
    finish_test();
  end

  initial
  begin
    i_reset_n  = 1'h0;
    clk_run    = 1'h1;
    cmd_valid  = 1'h0;
    cmd_write  = 1'h0;
    cmd_addr   = '0;
    cmd_data   = '0;
    cmd_mask_n = '1;
    flt_if.k   = 1'h1;
    flt_if.kb  = 1'h1;
    flt_if.read_port_select_n = 1'h1;
    flt_if.write_port_select_n = 1'h1;
    flt_if.addr = '0;
    flt_if.d = '0;
    flt_if.low_lane_write_select_n = 1'h1;
    flt_if.high_lane_write_select_n = 1'h1;
    n_errors = 0;
    n_tests = 0;
    seed = 32'h0000C4B2;
    repeat (20) @(posedge i_sys_clk);
    i_reset_n <= 1'h1;
    repeat (3) @(posedge i_sys_clk);
    check("q_oe_idle", 32'(port_if.q_oe), 32'h0);
    check("flt_q_oe_idle", 32'(flt_if.q_oe), 32'h0);
    for (int i = 0; i < 16; i++)
      push(1'h1, AW'(4 * i), 72'({rnd(), rnd(), rnd()}), 8'h00, 2000, ok);
    for (int i = 0; i < 40; i++)
    begin
      a = (i == 0) ? 6'h3F : AW'(rnd());
      push(1'h1, a, 72'({rnd(), rnd(), rnd()}), 8'(rnd()), 2000, ok);
      push(1'h0, a, '0, 8'hFF, 2000, ok);
      push(1'h0, AW'(rnd()), '0, 8'hFF, 2000, ok);
    end
    drain();
    clk_run <= 1'h0;
    repeat (4) @(posedge i_sys_clk);
    acc = 0;
    ok = 1'h1;
    while (ok && acc < 12)
    begin
      push(1'h0, AW'(rnd()), '0, 8'hFF, 4, ok);
      acc += int'(ok);
    end
    check("fifo_refused", 32'(ok), 32'h0);
    check("fifo_depth", 32'(acc), 32'(`B4_FIFO_DEPTH));
    clk_run <= 1'h1;
    drain();
    foreach (fw[i])
      fw[i] = 18'(rnd());
    foreach (fw[i])
      exp2_q.push_back(fw[i]);
    st(1'h0, 1'h1, 1'h1, 6'h05, '0, 2'h3);
    st(1'h1, 1'h1, 1'h0, 6'h05, '0, 2'h3);
    st(1'h0, 1'h1, 1'h1, 6'h05, '0, 2'h3);
    st(1'h1, 1'h1, 1'h1, 6'h05, fw[0], 2'h0);
    st(1'h0, 1'h1, 1'h1, 6'h05, fw[1], 2'h0);
    st(1'h1, 1'h0, 1'h0, 6'h05, fw[2], 2'h0);
    st(1'h0, 1'h0, 1'h0, 6'h05, fw[3], 2'h0);
    st(1'h1, 1'h0, 1'h0, 6'h20, fw[3], 2'h3);
    st(1'h0, 1'h1, 1'h1, 6'h20, fw[3], 2'h3);
    for (int i = 0; i < 4; i++)
      st(1'(i % 2 == 0), 1'h1, 1'h1, 6'h20, fw[4 + i], 2'h0);
    st(1'h1, 1'h0, 1'h1, 6'h20, fw[7], 2'h3);
    for (int i = 0; i < 14; i++)
      st(1'(i % 2), 1'h1, 1'h1, 6'h20, fw[7], 2'h3);
    drain();
    finish_test();
  end
endmodule : burst4_ddr_sram_port_bench
